// ---- verilog/adcsp_port.sv ----
// Serial control and conversion sequencer of a four-channel 12-bit
// successive-approximation converter, with a buffered result stream.
// Assumes the serial pins, shutdown and comparator arrive asynchronously
// and that the serial clock is far slower than clk_sys_in.
`timescale 1ns/1ps
module adcsp_port
   import adcsp_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Serial pins.
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic din_in,
   output logic dout_out,
   output logic dout_oe_out,
   output logic result_strobe_out,
   output logic result_strobe_oe_out,
   // Shutdown pin and status.
   input wire logic shutdown_n_in,
   output logic shutdown_out,
   output logic busy_out,
   output logic [1:0] power_mode_out,
   // Analog front end control.
   input wire logic comparator_in,
   output logic track_out,
   output logic hold_to_neg_out,
   output logic [3:0] pos_sel_out,
   output logic [4:0] neg_sel_out,
   output logic [11:0] dac_code_out,
   // Result stream: {sel[2:0], bipolar, result[11:0]}.
   output logic result_valid_out,
   input wire logic result_ready_in,
   output logic [15:0] result_data_out
);
   typedef struct packed {
      adcsp_state_e state;
      logic sclk_prev;
      logic rx_active;
      logic rx_full;
      logic [3:0] rx_cnt;
      logic [7:0] rx_sh;
      logic [7:0] cfg;
      logic [2:0] mux_sel;
      logic [3:0] pos_sel;
      logic [4:0] neg_sel;
      logic track;
      logic hold_neg;
      logic [3:0] conv_cnt;
      logic [11:0] trial;
      logic [11:0] result;
      logic dout;
      logic strobe;
      logic push;
      logic [15:0] push_data;
   } adcsp_core_s;

   adcsp_core_s r_ff;
   adcsp_core_s nxt_r;
   logic [4:0] pins_s;
   logic sclk_s;
   logic cs_n_s;
   logic din_s;
   logic shutdown_n_s;
   logic comp_s;
   logic rise;
   logic fall;
   logic fifo_ready;
   logic start_ok;
   logic bipolar;
   logic [3:0] bidx;
   logic in_bits;

   // Every serial input, shutdown and comparator pin passes two flops; the serial clock is sampled, not used
   // as a clock, so the whole block stays in one domain.
   adcsp_sync #(
      .W(5),
      .RST(ADCSP_PIN_RST)
   ) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .d_in({sclk_in, cs_n_in, din_in, shutdown_n_in, comparator_in}),
      .q_out(pins_s)
   );

   assign sclk_s = pins_s[4];
   assign cs_n_s = pins_s[3];
   assign din_s = pins_s[2];
   assign shutdown_n_s = pins_s[1];
   assign comp_s = pins_s[0];

   // Serial clock edges drive shifting and conversion steps alike.
   assign rise = sclk_s && !r_ff.sclk_prev;
   assign fall = !sclk_s && r_ff.sclk_prev;
   assign bipolar = !r_ff.cfg[ADCSP_UNI_POS];

   // A new start bit is refused while the result buffer is full, so a
   // conversion begun from idle always has room for its result; a restart from ADCSP_RESTART_CNT on is checked before the running result is pushed.
   assign start_ok = !r_ff.rx_full && fifo_ready &&
                     ((r_ff.state == ADCSP_IDLE) ||
                      ((r_ff.state == ADCSP_CONV) &&
                       (r_ff.conv_cnt >= ADCSP_RESTART_CNT)));

   always_comb begin
      nxt_r = r_ff;
      nxt_r.push = 1'b0;
      nxt_r.sclk_prev = sclk_s;
      bidx = ADCSP_LAST_CNT - 4'(r_ff.conv_cnt + 4'h1);
      in_bits = 1'b0;
      if (!shutdown_n_s) begin
         nxt_r.state = ADCSP_DOWN;
         nxt_r.rx_active = 1'b0;
         nxt_r.rx_full = 1'b0;
         nxt_r.rx_cnt = '0;
         nxt_r.track = 1'b0;
         nxt_r.hold_neg = 1'b0;
         nxt_r.conv_cnt = '0;
         nxt_r.dout = 1'b0;
         nxt_r.strobe = 1'b0;
      end else begin
         if (r_ff.state == ADCSP_DOWN) begin
            nxt_r.state = ADCSP_IDLE;
         end
         if (cs_n_s && !r_ff.rx_full) begin
            nxt_r.rx_active = 1'b0;
            nxt_r.rx_cnt = '0;
            if (r_ff.state != ADCSP_CONV) begin
               nxt_r.track = 1'b0;
            end
         end
         if (rise && !cs_n_s) begin
            // Leading zeros are dropped until the first one arrives.
            if (r_ff.rx_active || (din_s && start_ok)) begin
               nxt_r.rx_sh = {r_ff.rx_sh[6:0], din_s};
               nxt_r.rx_cnt = r_ff.rx_cnt + 4'h1;
               nxt_r.rx_active = 1'b1;
               if (r_ff.rx_cnt == ADCSP_CTRL_LAST) begin
                  nxt_r.rx_active = 1'b0;
                  nxt_r.rx_full = 1'b1;
               end
            end
            if (r_ff.state == ADCSP_CONV) begin
               nxt_r.conv_cnt = r_ff.conv_cnt + 4'h1;
               nxt_r.strobe = (nxt_r.conv_cnt == ADCSP_STRB_CNT);
               nxt_r.dout = 1'b0;
               in_bits = (nxt_r.conv_cnt >= ADCSP_FIRST_CNT) &&
                         (nxt_r.conv_cnt <= ADCSP_LAST_CNT);
               if (in_bits) begin
                  // One decision per rise, most significant first.
                  nxt_r.result[bidx] = comp_s;
                  nxt_r.trial[bidx] = comp_s;
                  if (bidx != 4'h0) begin
                     nxt_r.trial[4'(bidx - 4'h1)] = 1'b1;
                  end
                  nxt_r.dout = comp_s ^ (bipolar &&
                               (bidx == ADCSP_MSB_IDX));
               end
               if (nxt_r.conv_cnt == ADCSP_CONV_CLKS) begin
                  nxt_r.state = ADCSP_IDLE;
                  nxt_r.hold_neg = 1'b0;
                  nxt_r.push = 1'b1;
                  nxt_r.push_data = {r_ff.cfg[ADCSP_SEL_MSB:ADCSP_SEL_LSB],
                                     bipolar,
                                     nxt_r.result ^
                                     (bipolar ? ADCSP_DAC_MID : 12'h000)};
               end
            end else begin
               nxt_r.dout = 1'b0;
               nxt_r.strobe = 1'b0;
            end
         end
         if (fall && !cs_n_s) begin
            if (r_ff.rx_active && (r_ff.rx_cnt == ADCSP_TRACK_BIT)) begin
               nxt_r.track = 1'b1;
               nxt_r.mux_sel = r_ff.rx_sh[3:1];
            end
            if (r_ff.rx_full) begin
               nxt_r.track = 1'b0;
               nxt_r.hold_neg = 1'b1;
               nxt_r.rx_full = 1'b0;
               nxt_r.rx_cnt = '0;
               nxt_r.cfg = r_ff.rx_sh;
               nxt_r.mux_sel = r_ff.rx_sh[ADCSP_SEL_MSB:ADCSP_SEL_LSB];
               nxt_r.state = ADCSP_CONV;
               nxt_r.conv_cnt = '0;
               nxt_r.trial = ADCSP_DAC_MID;
               nxt_r.result = '0;
            end
         end
      end
      // The positive side follows the select code in either mode.
      case (nxt_r.mux_sel)
         ADCSP_SEL_A: nxt_r.pos_sel = 4'h1;
         ADCSP_SEL_B: nxt_r.pos_sel = 4'h2;
         ADCSP_SEL_C: nxt_r.pos_sel = 4'h4;
         ADCSP_SEL_D: nxt_r.pos_sel = 4'h8;
         default: nxt_r.pos_sel = 4'h0;
      endcase
      if (nxt_r.cfg[ADCSP_SGL_POS]) begin
         nxt_r.neg_sel = 5'h10;
      end else begin
         case (nxt_r.mux_sel)
            ADCSP_SEL_A: nxt_r.neg_sel = 5'h02;
            ADCSP_SEL_B: nxt_r.neg_sel = 5'h01;
            ADCSP_SEL_C: nxt_r.neg_sel = 5'h08;
            ADCSP_SEL_D: nxt_r.neg_sel = 5'h04;
            default: nxt_r.neg_sel = 5'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   adcsp_fifo #(
      .W(ADCSP_FIFO_W),
      .DEPTH(ADCSP_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(r_ff.push),
      .in_ready_out(fifo_ready),
      .in_data_in(r_ff.push_data),
      .out_valid_out(result_valid_out),
      .out_ready_in(result_ready_in),
      .out_data_out(result_data_out)
   );

   assign dout_out = r_ff.dout;
   assign dout_oe_out = !cs_n_s;
   assign result_strobe_out = r_ff.strobe;
   assign result_strobe_oe_out = !cs_n_s;
   assign shutdown_out = (r_ff.state == ADCSP_DOWN);
   assign busy_out = (r_ff.state == ADCSP_CONV);
   assign power_mode_out = r_ff.cfg[ADCSP_PD_MSB:ADCSP_PD_LSB];
   assign track_out = r_ff.track;
   assign hold_to_neg_out = r_ff.hold_neg;
   assign pos_sel_out = r_ff.pos_sel;
   assign neg_sel_out = r_ff.neg_sel;
   assign dac_code_out = r_ff.trial;
endmodule

// ---- common/adcsp_pkg.sv ----
// Constants and types shared by the serial conversion port and its helpers.
// Assumes nothing of its surroundings; it holds definitions only.
package adcsp_pkg;
   // Control byte framing and field positions.
   localparam logic [3:0] ADCSP_CTRL_LAST = 4'h7;
   localparam logic [3:0] ADCSP_TRACK_BIT = 4'h5;
   localparam int ADCSP_SEL_MSB = 6;
   localparam int ADCSP_SEL_LSB = 4;
   localparam int ADCSP_UNI_POS = 3;
   localparam int ADCSP_SGL_POS = 2;
   localparam int ADCSP_PD_MSB = 1;
   localparam int ADCSP_PD_LSB = 0;
   // Conversion sequencing, counted in serial clock periods.
   localparam logic [3:0] ADCSP_STRB_CNT = 4'h1;
   localparam logic [3:0] ADCSP_FIRST_CNT = 4'h2;
   localparam logic [3:0] ADCSP_LAST_CNT = 4'hD;
   localparam logic [3:0] ADCSP_RESTART_CNT = 4'h7;
   localparam logic [3:0] ADCSP_CONV_CLKS = 4'hF;
   localparam int ADCSP_RES_BITS = 12;
   localparam logic [3:0] ADCSP_MSB_IDX = 4'hB;
   localparam logic [11:0] ADCSP_DAC_MID = 12'h800;
   // Channel select codes, sel2 as the most significant bit.
   localparam logic [2:0] ADCSP_SEL_A = 3'h1;
   localparam logic [2:0] ADCSP_SEL_B = 3'h5;
   localparam logic [2:0] ADCSP_SEL_C = 3'h2;
   localparam logic [2:0] ADCSP_SEL_D = 3'h6;
   // Result buffer shape and synchroniser reset pattern.
   localparam int ADCSP_FIFO_W = 16;
   localparam int ADCSP_FIFO_DEPTH = 32;
   localparam logic [4:0] ADCSP_PIN_RST = 5'h0A;
   typedef enum logic [1:0] {
      ADCSP_IDLE,
      ADCSP_CONV,
      ADCSP_DOWN
   } adcsp_state_e;
endpackage

// ---- verilog/adcsp_sync.sv ----
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk_sys_in.
`timescale 1ns/1ps
module adcsp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Levels.
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } adcsp_sync_s;

   adcsp_sync_s r_ff;
   adcsp_sync_s nxt_r;

   always_comb begin
      nxt_r.meta = d_in;
      nxt_r.stable = r_ff.meta;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         r_ff <= {RST, RST};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign q_out = r_ff.stable;
endmodule

// ---- verilog/adcsp_fifo.sv ----
// Synchronous first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on clk_sys_in; depth is a power of two.
`timescale 1ns/1ps
module adcsp_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Filling side.
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   // Draining side.
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } adcsp_fifo_s;

   adcsp_fifo_s r_ff;
   adcsp_fifo_s nxt_r;
   logic full;
   logic empty;

   // Pointers carry one extra bit so full and empty stay distinct.
   assign empty = (r_ff.wr == r_ff.rd);
   assign full = (r_ff.wr[AW-1:0] == r_ff.rd[AW-1:0]) &&
                 (r_ff.wr[AW] != r_ff.rd[AW]);

   always_comb begin
      nxt_r = r_ff;
      if (in_valid_in && !full) begin
         nxt_r.mem[r_ff.wr[AW-1:0]] = in_data_in;
         nxt_r.wr = r_ff.wr + 1'b1;
      end
      if (out_ready_in && !empty) begin
         nxt_r.rd = r_ff.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = r_ff.mem[r_ff.rd[AW-1:0]];
endmodule

// ---- verif/adcsp_port_props.sv ----
// Timing properties of the serial conversion port, seen at its pins.
// Assumes a serial clock of about 40 system clocks per period.
`timescale 1ns/1ps
module adcsp_port_props
   import adcsp_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Inputs.
   input wire logic cs_n_in,
   input wire logic shutdown_n_in,
   input wire logic result_ready_in,
   // Outputs.
   input wire logic dout_oe_out,
   input wire logic result_strobe_out,
   input wire logic result_strobe_oe_out,
   input wire logic shutdown_out,
   input wire logic busy_out,
   input wire logic track_out,
   input wire logic hold_to_neg_out,
   input wire logic [3:0] pos_sel_out,
   input wire logic [4:0] neg_sel_out,
   input wire logic [11:0] dac_code_out,
   input wire logic result_valid_out,
   input wire logic [15:0] result_data_out
);
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   logic [9:0] bcnt;
   logic [5:0] scnt;
   logic [7:0] tcnt;
   always_ff @(posedge clk_sys_in) begin
      bcnt <= busy_out ? bcnt + 10'h1 : 10'h0;
      scnt <= result_strobe_out ? scnt + 6'h1 : 6'h0;
      tcnt <= track_out ? tcnt + 8'h1 : 8'h0;
   end
   a_track_len: assert property (
      $rose(hold_to_neg_out) |-> $past(tcnt) inside {[110:130]})
      else $error("acquisition length wrong");
   a_pins_float: assert property (
      $stable(cs_n_in)[*3] |-> dout_oe_out == !cs_n_in
      && result_strobe_oe_out == !cs_n_in) else $error("pin enable wrong");
   a_strobe_width: assert property (
      $fell(result_strobe_out) |-> $past(scnt) inside {[36:44]})
      else $error("strobe width wrong");
   a_strobe_busy: assert property (
      result_strobe_out |-> busy_out && hold_to_neg_out)
      else $error("strobe outside conversion");
   a_dac_mid: assert property (
      $rose(hold_to_neg_out) |-> dac_code_out == ADCSP_DAC_MID
      && !track_out) else $error("conversion start wrong");
   a_conv_len: assert property (
      $fell(busy_out) && !shutdown_out |-> $past(bcnt) inside {[540:640]})
      else $error("conversion length wrong");
   a_shutdown_entry: assert property (
      !shutdown_n_in [*4] |-> shutdown_out && !busy_out)
      else $error("shutdown not entered");
   a_route_onehot: assert property (
      $onehot0(pos_sel_out) && $onehot0(neg_sel_out)
      && (neg_sel_out[3:0] & pos_sel_out) == 4'h0) else $error("bad route");
   a_stream_hold: assert property (
      result_valid_out && !result_ready_in |=> result_valid_out
      && $stable(result_data_out)) else $error("stream word dropped");
endmodule
bind adcsp_port adcsp_port_props u_props (.*);

// ---- verif/adcsp_master.sv ----
// Serial master model: frames control bits and samples the answer pins.
// Assumes a 250 MHz system clock; the serial clock idles low.
`timescale 1ns/1ps
module adcsp_master (
   // Pacing clock.
   input wire logic clk_sys_in,
   // Serial link.
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out,
   input wire logic dout_in,
   input wire logic strobe_in
);
   localparam int HALF = 20;
   logic dbits [32];
   logic sbits [32];
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   end
   // Pins are read late in the high phase, well after the device moved them.
   task automatic xfer(input logic [31:0] b, input int n, input logic cs);
      @(negedge clk_sys_in);
      cs_n_out = cs;
      for (int i = 0; i < n; i++) begin
         din_out = b[31 - i];
         repeat (HALF) @(negedge clk_sys_in);
         sclk_out = 1'b1;
         repeat (HALF) @(negedge clk_sys_in);
         dbits[i] = dout_in;
         sbits[i] = strobe_in;
         sclk_out = 1'b0;
      end
   endtask
   task automatic rel();
      repeat (HALF) @(negedge clk_sys_in);
      cs_n_out = 1'b1;
      repeat (2 * HALF) @(negedge clk_sys_in);
   endtask
endmodule

// ---- verif/tb.sv ----
// Bench of the serial conversion port: framing, conversions, shutdown and
// result buffer back-pressure. Assumes the master model and the checker.
`timescale 1ns/1ps
module tb;
   import adcsp_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic sclk, cs_n, din, dout, doe, strb, soe, shutdown_n, in_down, busy;
   logic rdy, cmp, valid, trk;
   logic [1:0] pm;
   logic [3:0] pos;
   logic [4:0] neg;
   logic [11:0] dac, ain;
   logic [15:0] rdata;
   logic [15:0] q [$];
   logic [2:0] sels [4];
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   wire dpin = doe ? dout : 1'bz;
   wire spin = soe ? strb : 1'bz;
   always #2 clk_sys_in = ~clk_sys_in;
   adcsp_master m (.clk_sys_in, .sclk_out(sclk), .cs_n_out(cs_n),
      .din_out(din), .dout_in(dpin), .strobe_in(spin));
   adcsp_port dut (.clk_sys_in, .rst_n_in, .sclk_in(sclk), .cs_n_in(cs_n),
      .din_in(din), .dout_out(dout), .dout_oe_out(doe),
      .result_strobe_out(strb), .result_strobe_oe_out(soe),
      .shutdown_n_in(shutdown_n), .shutdown_out(in_down), .busy_out(busy),
      .power_mode_out(pm), .comparator_in(cmp), .track_out(trk),
      .hold_to_neg_out(), .pos_sel_out(pos), .neg_sel_out(neg),
      .dac_code_out(dac), .result_valid_out(valid),
      .result_ready_in(rdy), .result_data_out(rdata));
   // The analog side: an ideal comparator against a fixed input level.
   always @(negedge clk_sys_in) cmp <= (ain >= dac);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         report_and_stop();
      end
   end
   function automatic logic [8:0] route(input logic [2:0] s, input logic g);
      logic [3:0] p;
      p = (s == ADCSP_SEL_A) ? 4'h1 : (s == ADCSP_SEL_B) ? 4'h2 :
         (s == ADCSP_SEL_C) ? 4'h4 : 4'h8;
      return g ? {5'h10, p} : {1'b0, p[2], p[3], p[0], p[1], p};
   endfunction
   task automatic conv(input logic [7:0] c, input logic [11:0] a, input int z);
      logic [11:0] r;
      ain = a;
      r = c[3] ? a : {~a[11], a[10:0]};
      m.xfer({c, 24'h0} >> z, 24 + z, 1'b0);
      chk(m.sbits[8 + z], 1'b1);
      chk(m.sbits[9 + z], 1'b0);
      for (int i = 0; i < 12; i++) begin
         chk(m.dbits[9 + z + i], r[11 - i]);
      end
      chk({neg, pos}, route(c[6:4], c[2]));
      chk(pm, c[1:0]);
      q.push_back({c[6:4], ~c[3], r});
   endtask
   task automatic pop_chk();
      logic [15:0] e;
      e = q.pop_front();
      chk(valid, 1'b1);
      chk(rdata, e);
      rdy = 1'b1;
      @(negedge clk_sys_in);
      rdy = 1'b0;
      @(negedge clk_sys_in);
   endtask
   task automatic t_frame();
      m.xfer(32'hFFFFFFFF, 8, 1'b1);
      chk(busy, 1'b0);
      chk(m.dbits[7], 1'bz);
      chk(m.sbits[7], 1'bz);
      m.xfer(32'hFFFFFFFF, 4, 1'b0);
      repeat (8) @(negedge clk_sys_in);
      chk(trk, 1'b0);
      m.xfer(32'hFFFFFFFF, 1, 1'b0);
      repeat (8) @(negedge clk_sys_in);
      chk(trk, 1'b1);
      m.rel();
      chk(trk, 1'b0);
      chk(busy, 1'b0);
      conv({1'b1, ADCSP_SEL_B, 4'hB}, 12'hFFF, 3);
      pop_chk();
      $display("frame test done");
   endtask
   task automatic t_shutdown();
      m.xfer({1'b1, ADCSP_SEL_C, 4'hF, 24'h0}, 12, 1'b0);
      chk(busy, 1'b1);
      shutdown_n = 1'b0;
      repeat (6) @(negedge clk_sys_in);
      chk(in_down, 1'b1);
      chk(busy, 1'b0);
      m.rel();
      shutdown_n = 1'b1;
      repeat (8) @(negedge clk_sys_in);
      chk(in_down, 1'b0);
      chk(valid, 1'b0);
      $display("shutdown test done");
   endtask
   task automatic t_fill();
      for (int i = 0; i < 32; i++) begin
         conv({1'b1, sels[i % 4], i[3:0]}, 12'(i * 131), 0);
      end
      // A full buffer must turn the next start bit away.
      m.xfer({8'hFF, 24'h0}, 24, 1'b0);
      chk(m.sbits[8], 1'b0);
      m.rel();
      for (int i = 0; i < 32; i++) begin
         pop_chk();
      end
      chk(valid, 1'b0);
      $display("fill test done");
   endtask
   initial begin
      shutdown_n = 1'b1;
      rdy = 1'b0;
      ain = 12'h0;
      sels = '{ADCSP_SEL_A, ADCSP_SEL_B, ADCSP_SEL_C, ADCSP_SEL_D};
      repeat (10) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      t_frame();
      t_shutdown();
      t_fill();
      report_and_stop();
   end
endmodule
